//--- common/brc_pkg.sv
package brc_pkg;
  // register byte addresses
  localparam logic [7:0] BRC_CTL_OFS = 8'h00;
  localparam logic [7:0] BRC_SCRATCH_OFS = 8'h40;
  localparam logic [7:0] BRC_SCRATCH_END = 8'h7C;
  // control field positions
  localparam int BRC_KEY_LSB = 0;
  localparam int BRC_POL_BIT = 16;
  localparam int BRC_DRIVE_BIT = 29;
  localparam int BRC_FORCE_BIT = 30;
  localparam int BRC_EN_BIT = 31;
  // unlock key
  localparam logic [7:0] BRC_UNLOCK_KEY = 8'h3A;
  // reset values
  localparam logic [7:0] BRC_KEY_RST = 8'h00;
  localparam logic BRC_POL_RST = 1'b1;
  localparam logic BRC_DRIVE_RST = 1'b1;
  localparam logic BRC_FORCE_RST = 1'b0;
  localparam logic BRC_EN_RST = 1'b1;
  localparam logic [31:0] BRC_SCRATCH_RST = 32'h00000000;
  // axi responses
  localparam logic [1:0] BRC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BRC_RESP_SLVERR = 2'h2;
  // write side of axi4-lite
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
  } brc_wreq_t;
  // read side of axi4-lite
  typedef struct packed {
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } brc_rreq_t;
endpackage

//--- rtl/brc_regulator_ctrl.sv
// The implementer's own choices: the address map and register access over AXI4-Lite.
module brc_regulator_ctrl #(
  parameter int SCRATCH_WORDS = 16
) (
  // clock and synchronous reset (backup-domain reset)
  input wire logic CLOCK,
  input wire logic SRST,
  // axi4-lite write channels
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [7:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // axi4-lite read channels
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [7:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // wakeup sources
  input wire logic ALARM_EVENT,
  input wire logic CENTURY_EVENT,
  input wire logic WAKE_INPUT_PIN,
  // regulator enable pin, two signals
  output logic REGULATOR_ENABLE_PIN_O,
  output logic REGULATOR_ENABLE_PIN_OE,
  // level of the wake pin after sync, for hibernate wakeup
  output logic WAKE_HIBERNATE
);
  import brc_pkg::*;

  // elaboration check: the word index decode serves exactly sixteen words
  if (SCRATCH_WORDS != 16)
  begin : g_bad_depth
    $error("scratch bank must hold sixteen words");
  end

  // control fields
  logic [7:0] key_r, key_nxt;
  logic pol_r, pol_nxt;
  logic drive_r, drive_nxt;
  logic force_r, force_nxt;
  logic en_r, en_nxt;
  // retained storage array
  logic [31:0] scratch_r [SCRATCH_WORDS];
  // write channel holding state
  logic aw_got_r, aw_got_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic w_got_r, w_got_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  // read channel state
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  // wake pin synchroniser
  logic wake_s1_r, wake_s2_r;
  // write decode
  logic do_write, ctl_hit, scr_hit;
  logic [31:0] wmask, ctl_old, ctl_new;
  logic [3:0] scr_idx;
  logic wake_evt;
  // pin level and drive, registered so the power pin never glitches
  logic pin_o_r, pin_o_nxt;
  logic pin_oe_r, pin_oe_nxt;

  // two-flop sync of the external wake pin
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end
    else
    begin
      wake_s1_r <= WAKE_INPUT_PIN;
      wake_s2_r <= wake_s1_r;
    end
  end

  // channel ready: take each when nothing pending on it
  assign AWREADY = !aw_got_r && !bvalid_r;
  assign WREADY = !w_got_r && !bvalid_r;
  assign ARREADY = !rvalid_r;
  assign BVALID = bvalid_r;
  assign BRESP = bresp_r;
  assign RVALID = rvalid_r;
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;
  assign WAKE_HIBERNATE = wake_s2_r;

  // write happens once address and data are both held
  assign do_write = aw_got_r && w_got_r && !bvalid_r;
  assign ctl_hit = (aw_addr_r[7:2] == BRC_CTL_OFS[7:2]);
  assign scr_hit = (aw_addr_r >= BRC_SCRATCH_OFS) && (aw_addr_r <= BRC_SCRATCH_END);
  assign scr_idx = aw_addr_r[5:2];
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  assign ctl_old = {en_r, force_r, drive_r, 12'h000, pol_r, 8'h00, key_r};
  assign ctl_new = (ctl_old & ~wmask) | (w_data_r & wmask);
  // alarm (incl. once-a-second alarm) or century rollover, or wake pin with polarity one
  assign wake_evt = ALARM_EVENT || CENTURY_EVENT || (wake_s2_r && pol_r);

  // bus channel next state
  always_comb
  begin
    aw_got_nxt = aw_got_r;
    aw_addr_nxt = aw_addr_r;
    w_got_nxt = w_got_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    // capture address
    if (AWVALID && AWREADY)
    begin
      aw_got_nxt = 1'b1;
      aw_addr_nxt = AWADDR;
    end
    // capture data
    if (WVALID && WREADY)
    begin
      w_got_nxt = 1'b1;
      w_data_nxt = WDATA;
      w_strb_nxt = WSTRB;
    end
    // issue response
    if (do_write)
    begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (ctl_hit || scr_hit) ? BRC_RESP_OKAY : BRC_RESP_SLVERR;
    end
    else if (bvalid_r && BREADY)
    begin
      bvalid_nxt = 1'b0;
    end
    // read
    if (ARVALID && ARREADY)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = BRC_RESP_OKAY;
      if (ARADDR[7:2] == BRC_CTL_OFS[7:2])
      begin
        rdata_nxt = ctl_old;
      end
      else if (ARADDR >= BRC_SCRATCH_OFS && ARADDR <= BRC_SCRATCH_END)
      begin
        rdata_nxt = scratch_r[ARADDR[5:2]];
      end
      else
      begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = BRC_RESP_SLVERR;
      end
    end
    else if (rvalid_r && RREADY)
    begin
      rvalid_nxt = 1'b0;
    end
  end

  // bus channel registers
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      aw_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_got_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= BRC_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= BRC_RESP_OKAY;
    end
    else
    begin
      aw_got_r <= aw_got_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_got_r <= w_got_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // control register next state
  always_comb
  begin
    key_nxt = key_r;
    pol_nxt = pol_r;
    drive_nxt = drive_r;
    force_nxt = force_r;
    en_nxt = en_r;
    if (do_write && ctl_hit)
    begin
      key_nxt = ctl_new[BRC_KEY_LSB +: 8];
      pol_nxt = ctl_new[BRC_POL_BIT];
      // set only; clear waits for reset
      force_nxt = force_r | ctl_new[BRC_FORCE_BIT];
      // key must already stand from an earlier write
      if (key_r == BRC_UNLOCK_KEY && !force_r)
      begin
        en_nxt = ctl_new[BRC_EN_BIT];
        drive_nxt = ctl_new[BRC_DRIVE_BIT];
      end
    end
    // wake event sets the stored bit and wins over a clear
    if (wake_evt)
    begin
      en_nxt = 1'b1;
    end
    // force-on keeps the bit set
    if (force_nxt)
    begin
      en_nxt = 1'b1;
    end
    // pin follows the next field values, so it changes on the same edge as the fields
    pin_o_nxt = en_nxt | force_nxt;
    // high-z only when drive off, key present and not forced
    pin_oe_nxt = drive_nxt || force_nxt || (key_nxt != BRC_UNLOCK_KEY);
  end

  // control registers; reset returns enable high
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      key_r <= BRC_KEY_RST;
      pol_r <= BRC_POL_RST;
      drive_r <= BRC_DRIVE_RST;
      force_r <= BRC_FORCE_RST;
      en_r <= BRC_EN_RST;
      // drive and enable reset high, so the pin is driven high
      pin_o_r <= BRC_EN_RST;
      pin_oe_r <= BRC_DRIVE_RST;
    end
    else
    begin
      key_r <= key_nxt;
      pol_r <= pol_nxt;
      drive_r <= drive_nxt;
      force_r <= force_nxt;
      en_r <= en_nxt;
      pin_o_r <= pin_o_nxt;
      pin_oe_r <= pin_oe_nxt;
    end
  end

  // retained scratch words, cleared only by backup reset
  genvar gi;
  generate
    for (gi = 0; gi < SCRATCH_WORDS; gi++)
    begin : g_scr
      logic [31:0] scr_nxt;
      always_comb
      begin
        scr_nxt = scratch_r[gi];
        if (do_write && scr_hit && scr_idx == 4'(gi))
        begin
          scr_nxt = (scratch_r[gi] & ~wmask) | (w_data_r & wmask);
        end
      end
      always_ff @(posedge CLOCK)
      begin
        if (SRST)
        begin
          scratch_r[gi] <= BRC_SCRATCH_RST;
        end
        else
        begin
          scratch_r[gi] <= scr_nxt;
        end
      end
    end
  endgenerate

  // pin outputs straight from their flops
  assign REGULATOR_ENABLE_PIN_O = pin_o_r;
  assign REGULATOR_ENABLE_PIN_OE = pin_oe_r;

  // assertions
  force_sticky_a: assert property (@(posedge CLOCK) disable iff (SRST) $rose(force_r) |=> force_r [*8])
    else $error("force-on bit cleared");
  force_holds_a: assert property (@(posedge CLOCK) disable iff (SRST) force_r |-> en_r && REGULATOR_ENABLE_PIN_OE)
    else $error("force-on not holding enable");
  wake_sets_a: assert property (@(posedge CLOCK) disable iff (SRST) wake_evt |=> en_r)
    else $error("wake event did not set enable");
  pin_wake_a: assert property (@(posedge CLOCK) disable iff (SRST) (wake_s2_r && pol_r) |=> en_r)
    else $error("wake pin did not set enable");
  locked_clear_a: assert property (@(posedge CLOCK) disable iff (SRST)
    (en_r && key_r != BRC_UNLOCK_KEY) |=> en_r)
    else $error("enable cleared without key");
  clear_cause_a: assert property (@(posedge CLOCK) disable iff (SRST)
    $fell(en_r) |-> $past(do_write && ctl_hit && key_r == BRC_UNLOCK_KEY && !force_r))
    else $error("enable cleared without unlocked write");
  reset_high_a: assert property (@(posedge CLOCK) $past(SRST) |-> en_r && REGULATOR_ENABLE_PIN_O)
    else $error("enable not high after reset");
  pin_value_a: assert property (@(posedge CLOCK) disable iff (SRST) drive_r |-> REGULATOR_ENABLE_PIN_O == en_r)
    else $error("pin does not follow enable");
  hiz_key_a: assert property (@(posedge CLOCK) disable iff (SRST) !REGULATOR_ENABLE_PIN_OE |-> key_r == BRC_UNLOCK_KEY)
    else $error("high impedance without key");
  holds_a: assert property (@(posedge CLOCK) disable iff (SRST) !do_write && !wake_evt |=> $stable(en_r))
    else $error("enable changed without cause");
endmodule

//--- testbench/backup_regulator_enable_ctrl_bench.sv
module backup_regulator_enable_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import brc_pkg::*;
  logic clock = 1'b0;
  logic srst, alarm, century, press, wake_pin, hib;
  brc_wreq_t wq;
  brc_rreq_t rq;
  logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pmic_on;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  // mirror of the control fields
  logic [7:0] key_m;
  logic drv_m, frc_m, en_m;
  logic [31:0] seed = 32'h4EE5EA55;
  // byte strobes used by the next write
  logic [3:0] strb_m = 4'hF;
  int fails = 0;
  int checks = 0;

  always #20 clock = ~clock;

  brc_regulator_ctrl brc_regulator_ctrl_i (.CLOCK(clock), .SRST(srst), .AWVALID(wq.awvalid), .AWREADY(awready),
    .AWADDR(wq.awaddr), .WVALID(wq.wvalid), .WREADY(wready), .WDATA(wq.wdata), .WSTRB(wq.wstrb), .BVALID(bvalid),
    .BREADY(wq.bready), .BRESP(bresp), .ARVALID(rq.arvalid), .ARREADY(arready), .ARADDR(rq.araddr),
    .RVALID(rvalid), .RREADY(rq.rready), .RDATA(rdata), .RRESP(rresp), .ALARM_EVENT(alarm),
    .CENTURY_EVENT(century), .WAKE_INPUT_PIN(wake_pin), .REGULATOR_ENABLE_PIN_O(pin_o),
    .REGULATOR_ENABLE_PIN_OE(pin_oe), .WAKE_HIBERNATE(hib));
  brc_pmic_model brc_pmic_model_i (.clock(clock), .enable_o(pin_o), .enable_oe(pin_oe), .press(press),
    .wake_pin(wake_pin), .pmic_on(pmic_on));

  task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s expected %h seen %h", w, e, s);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // every wait is bounded
  task automatic guard(inout int n);
    n++;
    if (n > 64)
    begin
      check("handshake", 32'h0, 32'h1);
      complete_run();
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    int n;
    logic aw, w, b;
    n = 0;
    b = 1'b0;
    @(posedge clock);
    wq <= '{1'b1, a, 1'b1, d, strb_m, 1'b1};
    while (!b)
    begin
      @(negedge clock);
      aw = wq.awvalid & awready;
      w = wq.wvalid & wready;
      b = bvalid;
      resp = bresp;
      @(posedge clock);
      if (aw)
        wq.awvalid <= 1'b0;
      if (w)
        wq.wvalid <= 1'b0;
      guard(n);
    end
    wq.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    int n;
    logic ar, r;
    n = 0;
    r = 1'b0;
    @(posedge clock);
    rq <= '{1'b1, a, 1'b1};
    while (!r)
    begin
      @(negedge clock);
      ar = rq.arvalid & arready;
      r = rvalid;
      d = rdata;
      resp = rresp;
      @(posedge clock);
      if (ar)
        rq.arvalid <= 1'b0;
      guard(n);
    end
    rq.rready <= 1'b0;
  endtask

  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // byte lanes of a partial write land over the old word
  function automatic logic [31:0] lane_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] v;
    v = o;
    for (int b = 0; b < 4; b++)
      if (s[b])
        v[8 * b +: 8] = n[8 * b +: 8];
    return v;
  endfunction

  function automatic logic [31:0] ctl_word(logic [7:0] k, logic d, logic f, logic e);
    logic [31:0] v;
    v = {24'h0, k};
    v[BRC_POL_BIT] = 1'b1;
    v[BRC_DRIVE_BIT] = d;
    v[BRC_FORCE_BIT] = f;
    v[BRC_EN_BIT] = e;
    return v;
  endfunction

  // pins and control word against the mirror
  task automatic settle_check();
    logic [31:0] d;
    logic [1:0] r;
    logic oe;
    @(negedge clock);
    oe = !(!drv_m && key_m == BRC_UNLOCK_KEY && !frc_m);
    check("pin level", {31'h0, pin_o}, {31'h0, en_m | frc_m});
    check("pin drive", {31'h0, pin_oe}, {31'h0, oe});
    check("wire", {31'h0, pmic_on}, {31'h0, oe & (en_m | frc_m)});
    axi_rd(BRC_CTL_OFS, d, r);
    d = d & ctl_word(8'hFF, 1'b1, 1'b1, !frc_m);
    check("ctl read", d, ctl_word(key_m, drv_m, frc_m, en_m) & ctl_word(8'hFF, 1'b1, 1'b1, !frc_m));
  endtask

  task automatic ctl_write(input logic [7:0] k, input logic d, input logic f, input logic e);
    logic [1:0] r;
    axi_wr(BRC_CTL_OFS, ctl_word(k, d, f, e), r);
    check("ctl bresp", {30'h0, r}, {30'h0, BRC_RESP_OKAY});
    // only a key held before this write unlocks, and force blocks it
    if (key_m == BRC_UNLOCK_KEY && !frc_m)
    begin
      en_m = e;
      drv_m = d;
    end
    frc_m = frc_m | f;
    key_m = k;
    settle_check();
  endtask

  task automatic wake(input int src);
    ctl_write(BRC_UNLOCK_KEY, 1'b1, 1'b0, 1'b0);
    @(posedge clock);
    alarm <= (src == 0);
    century <= (src == 1);
    press <= (src == 2);
    repeat (5) @(posedge clock);
    @(negedge clock);
    check("hibernate wake", {31'h0, hib}, {31'h0, src == 2});
    @(posedge clock);
    alarm <= 1'b0;
    century <= 1'b0;
    press <= 1'b0;
    en_m = 1'b1;
    repeat (4) @(posedge clock);
    settle_check();
  endtask

  task automatic mirror_reset();
    key_m = BRC_KEY_RST;
    drv_m = BRC_DRIVE_RST;
    frc_m = BRC_FORCE_RST;
    en_m = BRC_EN_RST;
  endtask

  initial
  begin
    logic [31:0] d, s0;
    logic [1:0] r;
    logic [7:0] a;
    srst = 1'b1;
    wq = '0;
    rq = '0;
    alarm = 1'b0;
    century = 1'b0;
    press = 1'b0;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    mirror_reset();
    settle_check();
    ctl_write(8'h5C, 1'b1, 1'b0, 1'b0);
    ctl_write(BRC_UNLOCK_KEY, 1'b1, 1'b0, 1'b1);
    ctl_write(BRC_UNLOCK_KEY, 1'b1, 1'b0, 1'b0);
    ctl_write(BRC_UNLOCK_KEY, 1'b1, 1'b0, 1'b0);
    ctl_write(BRC_UNLOCK_KEY, 1'b1, 1'b0, 1'b1);
    $display("test unlock done");
    for (int i = 0; i < 3; i++)
      wake(i);
    $display("test wake done");
    ctl_write(BRC_UNLOCK_KEY, 1'b0, 1'b0, 1'b1);
    ctl_write(8'h00, 1'b0, 1'b0, 1'b1);
    ctl_write(BRC_UNLOCK_KEY, 1'b1, 1'b0, 1'b1);
    ctl_write(BRC_UNLOCK_KEY, 1'b1, 1'b0, 1'b1);
    ctl_write(BRC_UNLOCK_KEY, 1'b1, 1'b1, 1'b1);
    ctl_write(BRC_UNLOCK_KEY, 1'b0, 1'b0, 1'b0);
    $display("test force done");
    s0 = seed;
    for (int i = 0; i < 17; i++)
    begin
      a = (i == 16) ? 8'h20 : BRC_SCRATCH_OFS + 8'(4 * i);
      seed = lfsr_next(seed);
      axi_rd(a, d, r);
      check("scratch reset", d, (i == 16) ? 32'h0 : BRC_SCRATCH_RST);
      axi_wr(a, seed, r);
      check("write resp", {30'h0, r}, {30'h0, (i == 16) ? BRC_RESP_SLVERR : BRC_RESP_OKAY});
    end
    seed = s0;
    for (int i = 0; i < 17; i++)
    begin
      a = (i == 16) ? 8'h20 : BRC_SCRATCH_OFS + 8'(4 * i);
      seed = lfsr_next(seed);
      axi_rd(a, d, r);
      check("scratch data", d, (i == 16) ? 32'h0 : seed);
      check("read resp", {30'h0, r}, {30'h0, (i == 16) ? BRC_RESP_SLVERR : BRC_RESP_OKAY});
      // partial write with random byte lanes over the known word
      if (i < 16)
      begin
        strb_m = seed[7:4];
        axi_wr(a, ~seed, r);
        strb_m = 4'hF;
        axi_rd(a, d, r);
        check("lane merge", d, lane_merge(seed, ~seed, seed[7:4]));
      end
    end
    $display("test scratch done");
    @(posedge clock);
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    mirror_reset();
    settle_check();
    $display("test second reset done");
    complete_run();
  end
endmodule

//--- testbench/brc_pmic_model.sv
module brc_pmic_model #(
  parameter logic PULL_LEVEL = 1'b0
) (
  // clock and pin from the block
  input wire logic clock,
  input wire logic enable_o,
  input wire logic enable_oe,
  // button and what the regulator sees
  input wire logic press,
  output logic wake_pin,
  output logic pmic_on
);
  // a released pin falls to the board pull, so high-z is seen as off
  assign pmic_on = enable_oe ? enable_o : PULL_LEVEL;
  // button gives a logic high while pressed
  always_ff @(posedge clock) wake_pin <= press;
endmodule
